/* logic/ued_endpoint_descriptor_dma.sv */
// endpoint descriptor fetch, data dma and writeback engine with wishbone registers
//
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "ued_consts.svh"

module ued_endpoint_descriptor_dma
  import ued_pkg::*;
(
  input  wire logic             ref_clk,       // 100 MHz clock
  input  wire logic             sys_rst,       // synchronous reset, active high
  input  wire logic             clkEn,         // freezes all state while low
  // wishbone slave
  input  wire logic             wbCyc,         // cycle
  input  wire logic             wbStb,         // strobe
  input  wire logic             wbWe,          // write enable
  input  wire logic [7:0]       wbAdr,         // byte address
  input  wire logic [3:0]       wbSel,         // byte lanes
  input  wire ued_pkg::ued_word_t wbDatI,      // write data
  output var  ued_pkg::ued_word_t wbDatO,      // read data
  output var  logic             wbAck,         // acknowledge
  // token side from the serial engine
  input  wire logic             tokValid,      // token pulse
  input  wire logic [3:0]       tokPid,        // token pid
  input  wire logic [3:0]       tokEp,         // endpoint number
  output var  logic             tokBusy,       // engine busy with a token
  output var  logic             tokSkip,       // pulse: entry not owned, nak
  // byte stream
  input  wire logic [7:0]       rxByte,        // received byte
  input  wire logic             rxValid,       // received byte strobe
  input  wire logic             rxLast,        // end of received packet
  output var  logic [7:0]       txByte,        // byte to transmit
  output var  logic             txValid,       // transmit byte strobe
  input  wire logic             txReady,       // serial engine takes byte
  output var  logic             txToggle,      // data toggle of entry
  // system memory master, one 32-bit access at a time
  output var  logic             memReq,        // request
  output var  logic             memWe,         // write
  output var  logic [31:0]      memAddr,       // byte address
  output var  logic [3:0]       memSel,        // byte lanes
  output var  ued_pkg::ued_word_t memWdata,    // write data
  input  wire ued_pkg::ued_word_t memRdata,    // read data
  input  wire logic             memAck,        // same-clock completion
  output var  logic             token_done_irq // level, cleared by writing DONE
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  ued_state_t state_r, state_nxt;
  logic [`UED_PAGE_W-1:0] table_base_page_r;
  logic [15:0] epEn_r;
  logic [31:0] oddSel_r;
  logic [31:0] ctl_r, ptr_r, addr_r;
  logic [`UED_BCNT_W-1:0] cnt_r;
  logic [3:0] pid_r, ep_r;
  logic tx_r, odd_r, stop_r;
  logic [15:0] stat_r;

  wire isTx     = (tokPid == `UED_TOK_IN);
  wire isRx     = (tokPid == `UED_TOK_OUT) || (tokPid == `UED_TOK_SETUP);
  wire [4:0] selIdx = {tokEp, isTx};
  wire [4:0] curIdx = {ep_r, tx_r};

  // page | endpoint | direction | odd | three byte bits, for fetch and writeback
  function automatic logic [31:0] ued_entry_addr(
    input logic [`UED_PAGE_W-1:0] page,
    input logic [`UED_EP_W-1:0]   ep,
    input logic                   tx,
    input logic                   odd
  );
    ued_entry_addr = {page, ep, tx, odd, 3'h0};
  endfunction

  // sixteen bytes per endpoint direction, even entry then odd entry
  wire [31:0] entryAddr = ued_entry_addr(table_base_page_r, ep_r, tx_r, odd_r);
  wire [31:0] fetchAddr = ued_entry_addr(table_base_page_r, tokEp, isTx, oddSel_r[selIdx]);
  wire owned    = memRdata[`UED_BIT_OWN];
  wire retain   = ctl_r[`UED_BIT_RETAIN];
  wire hold     = ctl_r[`UED_BIT_HOLD];
  wire [`UED_BCNT_W-1:0] bcnt = ctl_r[`UED_BCNT_LSB +: `UED_BCNT_W];
  wire countEnd = (cnt_r == bcnt);

  // writeback word keeps toggle, writes pid bits over the flag bits except set retain and hold
  wire [7:0] ctlByte = {retain ? ctl_r[`UED_BIT_OWN] : 1'b0,
                        ctl_r[`UED_BIT_TOGGLE],
                        1'b0,
                        retain ? 1'b1 : pid_r[3],
                        hold   ? 1'b1 : pid_r[2],
                        pid_r[1:0], 1'b0};
  wire [31:0] wbWord = {6'h00, cnt_r, 8'h00, ctlByte};

  // ---------------------------------------------------------------
  // token state machine
  // ---------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      UED_IDLE: if (tokValid && epEn_r[tokEp] && (isTx || isRx)) state_nxt = UED_RD0;
      UED_RD0:  if (memAck) state_nxt = owned ? UED_RD1 : UED_IDLE;
      UED_RD1:  if (memAck) state_nxt = UED_DATA;
      UED_DATA: if (stop_r && !memReq) state_nxt = UED_WB;
      UED_WB:   if (memAck) state_nxt = UED_DONE;
      UED_DONE: state_nxt = UED_IDLE;
      default:  state_nxt = UED_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // register read decode
  // ---------------------------------------------------------------
  wire [31:0] rdData;
  assign rdData = (wbAdr == `UED_REG_PAGE) ? {table_base_page_r, 9'h000} :
                  (wbAdr == `UED_REG_EPEN) ? {16'h0000, epEn_r} :
                  (wbAdr == `UED_REG_STAT) ? {16'h0000, stat_r} :
                  (wbAdr == `UED_REG_CTRL) ? {27'h0, state_r == UED_IDLE, 4'h0} :
                  (wbAdr == `UED_REG_DONE) ? {31'h0, token_done_irq} : 32'h0;

  // ---------------------------------------------------------------
  // data path decode
  // ---------------------------------------------------------------
  // one byte per memory access keeps the lanes simple at the cost of bandwidth
  wire [1:0]             lane     = addr_r[1:0];
  wire [7:0]             memByte  = memRdata[lane*8 +: 8];
  wire                   dataStep = rxValid && !stop_r && !countEnd;
  wire [31:0]            nextAddr = hold ? addr_r : addr_r + 32'h1;
  wire [31:0]            wordAddr = {addr_r[31:2], 2'b00};
  wire [`UED_BCNT_W-1:0] cntInc   = cnt_r + 1'b1;

  // ---------------------------------------------------------------
  // events
  // ---------------------------------------------------------------
  wire takeTok  = (state_r == UED_IDLE) && (state_nxt == UED_RD0);
  wire rd0Ack   = (state_r == UED_RD0) && memAck;
  wire rd1Ack   = (state_r == UED_RD1) && memAck;
  wire inData   = (state_r == UED_DATA);
  // transmit fetches the next byte only once the serial engine took the last
  wire txFetch  = inData && tx_r && !memReq && !txValid && !stop_r;
  wire txLoaded = inData && tx_r && !txFetch && memAck;
  wire txTaken  = inData && tx_r && !txFetch && !memAck && txValid && txReady;
  // a received byte beyond the count or during a pending write is clipped
  wire rxDone   = inData && !tx_r && memReq && memAck;
  wire rxStore  = inData && !tx_r && dataStep && !memReq;
  wire rxEnd    = inData && !tx_r && rxLast && !memReq;
  // writeback waits for the last data access so its answer is not mistaken
  wire wbIssue  = inData && stop_r && !memReq;
  wire backAck  = (state_r == UED_WB) && memAck;
  wire busHit   = wbCyc && wbStb && !wbAck;
  wire busWr    = busHit && wbWe;
  wire ctrlClr  = busWr && (wbAdr == `UED_REG_CTRL) && wbSel[0] && wbDatI[0];
  wire doneClr  = busWr && (wbAdr == `UED_REG_DONE) && wbDatI[0];

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      state_r <= UED_IDLE;
    else if (clkEn)
      state_r <= state_nxt;
  end

  // ---------------------------------------------------------------
  // token capture
  // ---------------------------------------------------------------
  // fields are latched once so a later pulse cannot move the entry address
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pid_r <= 4'h0;
      ep_r  <= 4'h0;
      tx_r  <= 1'b0;
      odd_r <= 1'b0;
    end
    else if (clkEn && takeTok)
    begin
      pid_r <= tokPid;
      ep_r  <= tokEp;
      tx_r  <= isTx;
      odd_r <= oddSel_r[selIdx];
    end
  end

  // ---------------------------------------------------------------
  // entry words
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ctl_r    <= '0;
      ptr_r    <= '0;
      txToggle <= 1'b0;
    end
    else if (clkEn)
    begin
      if (rd0Ack)
        ctl_r <= memRdata;
      if (rd1Ack)
      begin
        ptr_r    <= memRdata;
        txToggle <= ctl_r[`UED_BIT_TOGGLE];
      end
    end
  end

  // ---------------------------------------------------------------
  // byte count and buffer address
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cnt_r  <= '0;
      addr_r <= '0;
      stop_r <= 1'b0;
    end
    else if (clkEn)
    begin
      if (takeTok)
      begin
        cnt_r  <= '0;
        stop_r <= 1'b0;
      end
      if (rd1Ack)
      begin
        addr_r <= memRdata;
        stop_r <= (bcnt == '0);
      end
      if (txTaken || rxStore)
      begin
        cnt_r  <= cntInc;
        addr_r <= nextAddr;
      end
      if (txTaken)
        stop_r <= (cntInc == bcnt);
      if (rxEnd)
        stop_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // memory master
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      memReq   <= 1'b0;
      memWe    <= 1'b0;
      memAddr  <= '0;
      memSel   <= 4'h0;
      memWdata <= '0;
    end
    else if (clkEn)
    begin
      if (takeTok)
      begin
        memReq  <= 1'b1;
        memWe   <= 1'b0;
        memSel  <= 4'hF;
        memAddr <= fetchAddr;
      end
      else if (rd0Ack)
      begin
        // no lock against the processor; an unowned entry just ends the token
        memReq  <= owned;
        memAddr <= entryAddr + 32'h4;
      end
      else if (rd1Ack)
        memReq <= 1'b0;
      else if (wbIssue)
      begin
        memReq   <= 1'b1;
        memWe    <= 1'b1;
        memSel   <= 4'hF;
        memAddr  <= entryAddr;
        memWdata <= wbWord;
      end
      else if (txFetch)
      begin
        memReq  <= 1'b1;
        memWe   <= 1'b0;
        memSel  <= 4'hF;
        memAddr <= wordAddr;
      end
      else if (rxStore)
      begin
        memReq   <= 1'b1;
        memWe    <= 1'b1;
        memAddr  <= wordAddr;
        memSel   <= 4'h1 << lane;
        memWdata <= {4{rxByte}};
      end
      else if (txLoaded || rxDone)
        memReq <= 1'b0;
      else if (backAck)
      begin
        memReq <= 1'b0;
        memWe  <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // transmit byte
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      txByte  <= 8'h00;
      txValid <= 1'b0;
    end
    else if (clkEn)
    begin
      if (txLoaded)
      begin
        txByte  <= memByte;
        txValid <= 1'b1;
      end
      else if (txTaken)
        txValid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // status, selectors and done flag
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      tokSkip        <= 1'b0;
      tokBusy        <= 1'b0;
      stat_r         <= 16'h0000;
      oddSel_r       <= '0;
      token_done_irq <= 1'b0;
    end
    else if (clkEn)
    begin
      tokSkip <= rd0Ack && !owned;
      tokBusy <= (state_nxt != UED_IDLE);
      if (state_r == UED_DONE)
        stat_r <= {8'h00, ep_r, tx_r, odd_r, 2'b00};
      // the selector flips only after a writeback, so a skipped entry is retried
      if (ctrlClr)
        oddSel_r <= '0;
      else if (backAck)
        oddSel_r[curIdx] <= ~odd_r;
      // set wins over a clear in the same cycle
      if (state_r == UED_DONE)
        token_done_irq <= 1'b1;
      else if (doneClr)
        token_done_irq <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  // ack one cycle after the strobe and never back to back
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      wbAck             <= 1'b0;
      wbDatO            <= '0;
      table_base_page_r <= '0;
      epEn_r            <= '0;
    end
    else if (clkEn)
    begin
      wbAck <= busHit;
      if (busHit && !wbWe)
        wbDatO <= rdData;
      if (busWr && (wbAdr == `UED_REG_PAGE) && wbSel[3])
        table_base_page_r <= wbDatI[31:9];
      else if (busWr && (wbAdr == `UED_REG_EPEN) && wbSel[0])
        epEn_r <= wbDatI[15:0];
    end
  end

endmodule

`default_nettype wire

/* logic/ued_consts.svh */
// constants for the endpoint descriptor dma block
`ifndef UED_CONSTS_SVH
`define UED_CONSTS_SVH

// word 0 of an entry: control byte and byte count; word 1: buffer pointer
`define UED_BIT_OWN       7
`define UED_BIT_TOGGLE    6
`define UED_BIT_RETAIN    4
`define UED_BIT_HOLD      3
`define UED_BIT_SYNC      2
`define UED_BCNT_LSB      16
`define UED_BCNT_W        10
`define UED_ENTRY_BYTES   8
`define UED_PAGE_W        23
`define UED_EP_W          4

// register byte offsets on the wishbone slave
`define UED_REG_PAGE      8'h00
`define UED_REG_EPEN      8'h04
`define UED_REG_STAT      8'h08
`define UED_REG_CTRL      8'h0C
`define UED_REG_DONE      8'h10

`define UED_TOK_OUT       4'h1
`define UED_TOK_IN        4'h9
`define UED_TOK_SETUP     4'hD

`endif

/* logic/ued_pkg.sv */
// types for the endpoint descriptor dma block
package ued_pkg;
  typedef enum logic [3:0] {
    UED_IDLE, UED_RD0, UED_RD1, UED_DATA, UED_WB, UED_DONE
  } ued_state_t;
  typedef logic [31:0] ued_word_t;
endpackage

/* test/ued_mem_model.sv */
// behavioural system memory on the engine's master port, with a slow mode
`timescale 1ns/100ps
`default_nettype none
module ued_mem_model
  import ued_pkg::*;
(
  input  wire logic               clk,   // clock
  input  wire logic               req,   // request
  input  wire logic               we,    // write
  input  wire logic [31:0]        addr,  // byte address
  input  wire logic [3:0]         sel,   // lanes
  input  wire ued_pkg::ued_word_t wdata, // write data
  output var  ued_pkg::ued_word_t rdata, // read data
  output var  logic               ack,   // completion pulse
  input  wire logic               slow   // one wait cycle per access
);
  ued_word_t mem [0:255];
  logic      waited = 1'b0;
  initial {ack, rdata} = '0;
  // read data is scrambled outside the answer cycle so stale values are never trusted
  always @(posedge clk)
  begin
    {ack, rdata, waited} <= {1'b0, ~rdata, 1'b0};
    if (req && !ack && (waited || !slow))
    begin
      {ack, rdata} <= {1'b1, mem[addr[9:2]]};
      for (int b = 0; b < 4; b++)
        if (we && sel[b]) mem[addr[9:2]][8*b +: 8] <= wdata[8*b +: 8];
    end
    else if (req && !ack)
      waited <= 1'b1;
  end
endmodule
`default_nettype wire

/* test/ued_dma_checker.sv */
// port assertions for the descriptor dma engine
`timescale 1ns/100ps
`default_nettype none
`include "ued_consts.svh"
module ued_dma_checker
  import ued_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic sys_rst, // reset
  input wire logic wbCyc, // cycle
  input wire logic wbStb, // strobe
  input wire logic wbAck, // ack
  input wire logic tokValid, // token
  input wire logic [3:0] tokPid, // pid
  input wire logic [3:0] tokEp, // endpoint
  input wire logic tokBusy, // busy
  input wire logic tokSkip, // skip
  input wire logic memReq, // request
  input wire logic memWe, // write
  input wire logic [31:0] memAddr, // address
  input wire logic [3:0] memSel, // lanes
  input wire ued_pkg::ued_word_t memWdata, // write data
  input wire logic memAck, // completion
  input wire logic token_done_irq // done flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_tok_take; tokValid && !tokBusy; endsequence
  property p_ack_next; wbCyc && wbStb && !wbAck |=> wbAck; endproperty
  property p_ack_pulse; wbAck |=> !wbAck; endproperty
  property p_entry; s_tok_take ##1 memReq |-> !memWe && memAddr[2:0] == 3'h0
    && memAddr[8:5] == $past(tokEp) && memAddr[4] == ($past(tokPid) == `UED_TOK_IN); endproperty
  property p_mem_hold; memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWdata);
  endproperty
  property p_skip_cause; tokSkip |-> $past(memAck); endproperty
  property p_skip_pulse; tokSkip |=> !tokSkip; endproperty
  property p_release; memReq && memWe && memSel == 4'hF && memAddr[2:0] == 3'h0
    && !memWdata[`UED_BIT_RETAIN] |-> !memWdata[`UED_BIT_OWN]; endproperty
  property p_irq_time; $rose(token_done_irq) |-> $past(memAck, 2) && $past(memWe, 2)
    || $past(memAck) && $past(memWe); endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack");
  a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
  a_entry: assert property (p_entry) else $error("bad entry fetch");
  a_mem_hold: assert property (p_mem_hold) else $error("request moved");
  a_skip_cause: assert property (p_skip_cause) else $error("skip without fetch");
  a_skip_pulse: assert property (p_skip_pulse) else $error("long skip");
  a_release: assert property (p_release) else $error("entry kept");
  a_irq_time: assert property (p_irq_time) else $error("done flag early");
endmodule
bind ued_endpoint_descriptor_dma ued_dma_checker ued_dma_checker_i (.ref_clk, .sys_rst, .wbCyc,
  .wbStb, .wbAck, .tokValid, .tokPid, .tokEp, .tokBusy, .tokSkip, .memReq, .memWe, .memAddr,
  .memSel, .memWdata, .memAck, .token_done_irq);
`default_nettype wire

/* test/ued_endpoint_descriptor_dma_tb.sv */
// self-checking bench for the endpoint descriptor dma engine
`timescale 1ns/100ps
`default_nettype none
`include "ued_consts.svh"
module ued_endpoint_descriptor_dma_tb;
  import ued_pkg::*;
  logic ref_clk, sys_rst, wbCyc, wbStb, wbWe, wbAck, tokValid, tokBusy, tokSkip, rxValid;
  logic rxLast, txValid, txReady, txToggle, memReq, memWe, memAck, irq, armed, slow;
  logic [3:0] tokPid, tokEp, memSel;
  logic [7:0] wbAdr, rxByte, txByte;
  logic [7:0] txSeen [$];
  logic [31:0] memAddr, firstAddr;
  ued_word_t wbDatI, wbDatO, memWdata, memRdata, rd;
  int errors, comparisons;
  ued_endpoint_descriptor_dma ued_endpoint_descriptor_dma_i (.ref_clk, .sys_rst, .clkEn(1'b1),
    .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel(4'hF), .wbDatI, .wbDatO, .wbAck, .tokValid, .tokPid,
    .tokEp, .tokBusy, .tokSkip, .rxByte, .rxValid, .rxLast, .txByte, .txValid, .txReady,
    .txToggle, .memReq, .memWe, .memAddr, .memSel, .memWdata, .memRdata, .memAck,
    .token_done_irq(irq));
  ued_mem_model ued_mem_model_i (.clk(ref_clk), .req(memReq), .we(memWe), .addr(memAddr),
    .sel(memSel), .wdata(memWdata), .rdata(memRdata), .ack(memAck), .slow);
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // far side stalls every other cycle; first memory address after each token is kept
  always @(posedge ref_clk)
  begin
    txReady <= ~txReady;
    if (txValid && txReady) txSeen.push_back(txByte);
    if (tokValid && !tokBusy) armed <= 1'b1;
    else if (armed && memReq) {firstAddr, armed} <= {memAddr, 1'b0};
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish(input int late);
    errors += late;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wait_sig(ref logic s);
    for (int n = 0; s !== 1'b1; n++)
    begin
      if (n == 300) tally_and_finish(1);
      @(posedge ref_clk);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input ued_word_t d);
    {wbCyc, wbStb, wbWe, wbAdr, wbDatI} <= {2'b11, we, a, d};
    @(posedge ref_clk);
    wait_sig(wbAck);
    rd = wbDatO;
    {wbCyc, wbStb} <= 2'b00;
    @(posedge ref_clk);
  endtask
  task automatic token(input logic [3:0] pid, input logic [3:0] ep);
    {tokPid, tokEp, tokValid} <= {pid, ep, 1'b1};
    @(posedge ref_clk);
    tokValid <= 1'b0;
    @(posedge ref_clk);
  endtask
  initial
  begin
    {sys_rst, wbCyc, wbStb, wbWe, tokValid, rxValid, rxLast, txReady, armed, slow} = 10'h200;
    {wbAdr, wbDatI, tokPid, tokEp, rxByte, firstAddr} = '0;
    ued_mem_model_i.mem[8'h89] = 32'h0000_0300;
    ued_mem_model_i.mem[8'h88] = 32'h0003_00C0;
    ued_mem_model_i.mem[8'h85] = 32'h0000_0340;
    ued_mem_model_i.mem[8'h84] = 32'h0002_0098;
    ued_mem_model_i.mem[8'hD0] = 32'h0000_BBAA;
    {ued_mem_model_i.mem[8'h8A], ued_mem_model_i.mem[8'h8C]} = '0;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    wb(1'b0, `UED_REG_PAGE, '0);
    check(rd, 32'h0);
    wb(1'b1, `UED_REG_PAGE, 32'h0000_0200);
    wb(1'b1, `UED_REG_EPEN, 32'h0000_0003);
    wb(1'b0, 8'h14, '0);
    check(rd, 32'h0);
    // receive: each byte goes in only after the previous memory access is answered
    token(`UED_TOK_OUT, 4'h1);
    for (int i = 0; i < 5; i++)
    begin
      wait_sig(memAck);
      @(posedge ref_clk);
      if (i > 0 && i < 4)
      begin
        {rxByte, rxValid, rxLast} <= {8'(8'h11 * i), 1'b1, i == 3};
        @(posedge ref_clk);
        {rxValid, rxLast} <= 2'b00;
      end
    end
    wait_sig(irq);
    check(firstAddr, 32'h0000_0220);
    check({31'h0, txToggle}, 32'h1);
    check({31'h0, tokBusy}, 32'h0);
    check({8'h00, ued_mem_model_i.mem[8'hC0][23:0]}, 32'h0033_2211);
    check(ued_mem_model_i.mem[8'h88], 32'h0003_0042);
    wb(1'b0, `UED_REG_STAT, '0);
    check(rd, 32'h0000_0010);
    wb(1'b1, `UED_REG_DONE, 32'h0000_0001);
    // unowned transmit entry, then the odd receive entry
    token(`UED_TOK_IN, 4'h1);
    wait_sig(tokSkip);
    check(firstAddr, 32'h0000_0230);
    token(`UED_TOK_SETUP, 4'h1);
    wait_sig(tokSkip);
    check(firstAddr, 32'h0000_0228);
    check({31'h0, irq}, 32'h0);
    // transmit on slow memory from a retained entry with a fixed buffer address
    slow <= 1'b1;
    token(`UED_TOK_IN, 4'h0);
    wait_sig(irq);
    check({16'h0, txSeen[0], txSeen[1]}, 32'h0000_AAAA);
    check(ued_mem_model_i.mem[8'h84], 32'h0002_009A);
    check({31'h0, txToggle}, 32'h0);
    wb(1'b0, `UED_REG_STAT, '0);
    check(rd, 32'h0000_0008);
    tally_and_finish(0);
  end
endmodule
`default_nettype wire
